// *** hw/clock_synth_smbus_config_port.sv ***
// SMBus configuration slave and frequency select logic of the clock synthesizer
// Function
// - Answer only address bytes 1101_0010 and 1101_0011
// - Command bit 7 picks block or byte
// - Byte access indexes by command bits 6..0
// - Block bytes ascend from zero, MSB first
// - Stop after any byte keeps whole bytes
// - Block write: count byte then acked data
// - Block read returns count then data bytes
// - Configuration bytes load defaults at reset
// - Register bits enable each clock output
// - Code decodes to frequencies and gear
// - Latch straps once supply good seen low
// - Software code in byte 0 bits 4..0
// - Byte write and byte read sequences
module clock_synth_smbus_config_port (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic serial_data_pin_i,
   output logic serial_data_pin_o,
   output logic serial_data_pin_oe_o,
   input wire logic supply_good_n_i,
   input wire logic [4:0] freq_strap_code_i,
   input wire logic [1:0] swing_select_i,
   input wire logic sw_freq_src_i,
   output logic [1:0] swing_select_o,
   output logic [4:0] freq_code_o,
   output logic [10:0] cpu_freq_o,
   output logic [9:0] hub_clock_66_freq_o,
   output logic [8:0] pci_freq_o,
   output logic [1:0] gear_o,
   output logic [15:0] out_enable_o
);
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_SKIP} port_state_e;

   // Declared ahead of the arrays that it sizes
   localparam int NUM_BYTES_LOC = smbus_cfg_pkg::NUM_BYTES;

   port_state_e state_r, state_nxt;
   logic scl_q_r, sda_q_r;
   logic [3:0] bit_cnt_r, bit_cnt_nxt;
   logic [3:0] pos_r, pos_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic [6:0] ptr_r, ptr_nxt;
   logic ack_r, ack_nxt;
   logic read_r, read_nxt;
   logic block_r, block_nxt;
   logic cnt_pend_r, cnt_pend_nxt;
   logic mack_r, mack_nxt;
   logic oe_r, oe_nxt;
   logic [7:0] cfg_r [NUM_BYTES_LOC];
   logic [7:0] cfg_nxt [NUM_BYTES_LOC];
   logic [4:0] strap_r, strap_nxt;
   logic [1:0] swing_r, swing_nxt;
   logic latched_r, latched_nxt;
   logic scl_rise, scl_fall, start_seen, stop_seen;
   logic [7:0] rx_byte, load_val;
   logic wr_en, cmd_done;
   logic [4:0] code_sel;
   smbus_cfg_pkg::freq_s freq;

   // Out-of-range index reads as zero
   function automatic logic [7:0] rd_byte(input logic [6:0] idx,
                                          input logic [7:0] mem [NUM_BYTES_LOC]);
      if (idx < smbus_cfg_pkg::NUM_BYTES_IDX) begin
         return mem[idx[smbus_cfg_pkg::PTR_W-1:0]];
      end
      return smbus_cfg_pkg::BYTE_DEF;
   endfunction : rd_byte

   // Pins are synchronous to sys_clk, so one stage of history finds edges
   assign scl_rise = scl_i & ~scl_q_r;
   assign scl_fall = ~scl_i & scl_q_r;
   assign start_seen = scl_i & scl_q_r & sda_q_r & ~serial_data_pin_i;
   assign stop_seen = scl_i & scl_q_r & ~sda_q_r & serial_data_pin_i;
   assign rx_byte = {shift_r[6:0], serial_data_pin_i};
   // Count byte goes first on a block read, then bytes from the pointer
   assign load_val = cnt_pend_r ? smbus_cfg_pkg::BLOCK_COUNT : rd_byte(ptr_r, cfg_r);

   // Protocol sequencer
   always_comb begin
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      pos_nxt = pos_r;
      shift_nxt = shift_r;
      tx_nxt = tx_r;
      ptr_nxt = ptr_r;
      ack_nxt = ack_r;
      read_nxt = read_r;
      block_nxt = block_r;
      cnt_pend_nxt = cnt_pend_r;
      mack_nxt = mack_r;
      wr_en = 1'b0;
      cmd_done = 1'b0;
      if (start_seen) begin
         // Repeated start keeps pointer and command for the read phase
         state_nxt = ST_RX;
         bit_cnt_nxt = '0;
         pos_nxt = smbus_cfg_pkg::POS_ADDR;
      end else if (stop_seen) begin
         // Partial byte is simply dropped
         state_nxt = ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE, ST_SKIP: begin
            end
            ST_RX: begin
               if (scl_rise && bit_cnt_r != smbus_cfg_pkg::BYTE_FULL) begin
                  shift_nxt = rx_byte;
                  bit_cnt_nxt = bit_cnt_r + 4'h1;
                  if (bit_cnt_r == smbus_cfg_pkg::LAST_BIT) begin
                     ack_nxt = 1'b1;
                     if (pos_r != smbus_cfg_pkg::POS_MAX) begin
                        pos_nxt = pos_r + 4'h1;
                     end
                     if (pos_r == smbus_cfg_pkg::POS_ADDR) begin
                        ack_nxt = (rx_byte[7:1] == smbus_cfg_pkg::SLAVE_ADDR7);
                        read_nxt = rx_byte[0];
                     end else if (pos_r == smbus_cfg_pkg::POS_CMD) begin
                        cmd_done = 1'b1;
                        block_nxt = ~rx_byte[smbus_cfg_pkg::CMD_TYPE_BIT];
                        // Block uses index zero whatever the low bits hold
                        ptr_nxt = block_nxt ? '0 : rx_byte[6:0];
                        cnt_pend_nxt = block_nxt;
                     end else if (block_r && pos_r == smbus_cfg_pkg::POS_COUNT) begin
                        // Count byte acknowledged; stop ends the block
                        ack_nxt = 1'b1;
                     end else begin
                        wr_en = 1'b1;
                        ptr_nxt = ptr_r + 7'h01;
                     end
                  end
               end else if (scl_fall && bit_cnt_r == smbus_cfg_pkg::BYTE_FULL) begin
                  bit_cnt_nxt = '0;
                  state_nxt = ack_r ? ST_ACK : ST_SKIP;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (read_r) begin
                     state_nxt = ST_TX;
                     tx_nxt = load_val;
                     if (cnt_pend_r) begin
                        cnt_pend_nxt = 1'b0;
                     end else begin
                        ptr_nxt = ptr_r + 7'h01;
                     end
                  end else begin
                     state_nxt = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_r == smbus_cfg_pkg::LAST_BIT) begin
                     state_nxt = ST_MACK;
                     bit_cnt_nxt = '0;
                  end else begin
                     tx_nxt = {tx_r[6:0], 1'b0};
                     bit_cnt_nxt = bit_cnt_r + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  mack_nxt = ~serial_data_pin_i;
               end else if (scl_fall) begin
                  // Host not-acknowledge ends the read
                  if (mack_r) begin
                     state_nxt = ST_TX;
                     tx_nxt = load_val;
                     if (cnt_pend_r) begin
                        cnt_pend_nxt = 1'b0;
                     end else begin
                        ptr_nxt = ptr_r + 7'h01;
                     end
                  end else begin
                     state_nxt = ST_SKIP;
                  end
               end
            end
         endcase
      end
      // Open drain: only ever pull low
      oe_nxt = (state_nxt == ST_ACK) || (state_nxt == ST_TX && !tx_nxt[7]);
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         bit_cnt_r <= '0;
         pos_r <= '0;
         shift_r <= '0;
         tx_r <= '0;
         ptr_r <= '0;
         ack_r <= 1'b0;
         read_r <= 1'b0;
         block_r <= 1'b0;
         cnt_pend_r <= 1'b0;
         mack_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         scl_q_r <= scl_i;
         sda_q_r <= serial_data_pin_i;
         bit_cnt_r <= bit_cnt_nxt;
         pos_r <= pos_nxt;
         shift_r <= shift_nxt;
         tx_r <= tx_nxt;
         ptr_r <= ptr_nxt;
         ack_r <= ack_nxt;
         read_r <= read_nxt;
         block_r <= block_nxt;
         cnt_pend_r <= cnt_pend_nxt;
         mack_r <= mack_nxt;
         oe_r <= oe_nxt;
      end
   end

   // Configuration bytes; writes land only on a completed byte
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_en && ptr_r < smbus_cfg_pkg::NUM_BYTES_IDX) begin
         cfg_nxt[ptr_r[smbus_cfg_pkg::PTR_W-1:0]] = rx_byte;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         // Clocks run correctly without any host access
         for (int i = 0; i < NUM_BYTES_LOC; i++) begin
            cfg_r[i] <= smbus_cfg_pkg::BYTE_DEF;
         end
         cfg_r[smbus_cfg_pkg::SW_CODE_BYTE] <= smbus_cfg_pkg::BYTE0_DEF;
         cfg_r[smbus_cfg_pkg::EN_BYTE_A] <= smbus_cfg_pkg::BYTE1_DEF;
         cfg_r[smbus_cfg_pkg::EN_BYTE_B] <= smbus_cfg_pkg::BYTE2_DEF;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // Strap capture; supply good ignored once seen low
   always_comb begin
      strap_nxt = strap_r;
      swing_nxt = swing_r;
      latched_nxt = latched_r;
      if (!latched_r && !supply_good_n_i) begin
         strap_nxt = freq_strap_code_i;
         swing_nxt = swing_select_i;
         latched_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         strap_r <= '0;
         swing_r <= '0;
         latched_r <= 1'b0;
      end else begin
         strap_r <= strap_nxt;
         swing_r <= swing_nxt;
         latched_r <= latched_nxt;
      end
   end

   // Frequency selection and output enables, all registered
   assign code_sel = sw_freq_src_i ?
      cfg_r[smbus_cfg_pkg::SW_CODE_BYTE][smbus_cfg_pkg::SW_CODE_MSB:0] : strap_r;
   assign freq = smbus_cfg_pkg::freq_decode(code_sel);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         serial_data_pin_o <= 1'b0;
         swing_select_o <= '0;
         freq_code_o <= '0;
         cpu_freq_o <= '0;
         hub_clock_66_freq_o <= '0;
         pci_freq_o <= '0;
         gear_o <= '0;
         out_enable_o <= '0;
      end else begin
         serial_data_pin_o <= 1'b0;
         swing_select_o <= swing_r;
         freq_code_o <= code_sel;
         cpu_freq_o <= freq.cpu;
         hub_clock_66_freq_o <= freq.hub;
         pci_freq_o <= freq.pci;
         gear_o <= freq.gear;
         // Each buffer follows its bit, changeable at any time
         out_enable_o <= {cfg_r[smbus_cfg_pkg::EN_BYTE_A],
                          cfg_r[smbus_cfg_pkg::EN_BYTE_B]};
      end
   end

   assign serial_data_pin_oe_o = oe_r;

   addr_ack_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_r == ST_ACK && pos_r == smbus_cfg_pkg::POS_CMD)
      |-> shift_r[7:1] == smbus_cfg_pkg::SLAVE_ADDR7)
      else $error("address acknowledged without match");
   skip_release_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state_r == ST_SKIP |-> !serial_data_pin_oe_o)
      else $error("data pin driven while ignoring");
   cmd_ptr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      cmd_done && !start_seen |=> block_r == ~$past(rx_byte[7])
      && ptr_r == ($past(rx_byte[7]) ? $past(rx_byte[6:0]) : 7'h00))
      else $error("command decode wrong");
   byte_wr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      wr_en && ptr_r < smbus_cfg_pkg::NUM_BYTES_IDX
      |=> cfg_r[$past(ptr_r[smbus_cfg_pkg::PTR_W-1:0])] == $past(rx_byte)
      && ptr_r == $past(ptr_r) + 7'h01)
      else $error("write byte not stored");
   reset_def_a: assert property (@(posedge sys_clk_i)
      $past(sys_rst_i) && !sys_rst_i |-> cfg_r[smbus_cfg_pkg::EN_BYTE_A]
      == smbus_cfg_pkg::BYTE1_DEF && cfg_r[smbus_cfg_pkg::EN_BYTE_B] == smbus_cfg_pkg::BYTE2_DEF)
      else $error("defaults not loaded");
   strap_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      latched_r |=> $stable(strap_r) && $stable(swing_r) && latched_r)
      else $error("strap changed after latch");
   gear_map_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $stable(code_sel) ##1 $stable(code_sel) |-> freq_code_o == code_sel
      && gear_o == freq.gear)
      else $error("frequency decode mismatch");
   count_first_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      state_r != ST_TX && state_nxt == ST_TX && cnt_pend_r && !start_seen
      |=> tx_r == smbus_cfg_pkg::BLOCK_COUNT && !cnt_pend_r)
      else $error("block read count not first");
   out_en_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !sys_rst_i |=> out_enable_o == {$past(cfg_r[smbus_cfg_pkg::EN_BYTE_A]),
      $past(cfg_r[smbus_cfg_pkg::EN_BYTE_B])})
      else $error("output enable not following byte");
endmodule : clock_synth_smbus_config_port

// *** hw/smbus_cfg_pkg.sv ***
// Constants, types and frequency decode for the clock synthesizer SMBus port
package smbus_cfg_pkg;
   // 8-bit address byte 1101_0010 with the R/W bit stripped
   localparam logic [6:0] SLAVE_ADDR7 = 7'h69;
   localparam int NUM_BYTES = 8;
   localparam int PTR_W = 3;
   localparam logic [6:0] NUM_BYTES_IDX = 7'h08;
   localparam logic [7:0] BLOCK_COUNT = 8'h08;
   localparam int CMD_TYPE_BIT = 7;
   localparam int SW_CODE_BYTE = 0;
   localparam int EN_BYTE_A = 1;
   localparam int EN_BYTE_B = 2;
   localparam int SW_CODE_MSB = 4;
   // Power-up contents of the configuration bytes
   localparam logic [7:0] BYTE0_DEF = 8'h00;
   localparam logic [7:0] BYTE1_DEF = 8'hFF;
   localparam logic [7:0] BYTE2_DEF = 8'h7F;
   localparam logic [7:0] BYTE_DEF = 8'h00;
   // Byte position within a write phase
   localparam logic [3:0] POS_ADDR = 4'h0;
   localparam logic [3:0] POS_CMD = 4'h1;
   localparam logic [3:0] POS_COUNT = 4'h2;
   localparam logic [3:0] POS_MAX = 4'hF;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] BYTE_FULL = 4'h8;

   typedef enum logic [1:0] {GEAR_48, GEAR_64, GEAR_96} gear_e;
   // Frequencies in units of 100 kHz
   typedef struct packed {
      logic [10:0] cpu;
      logic [9:0] hub;
      logic [8:0] pci;
      gear_e gear;
   } freq_s;

   function automatic freq_s freq_decode(input logic [4:0] code);
      freq_s f;
      unique case (code)
         5'h00: f = '{11'd1007, 10'd671, 9'd336, GEAR_48};
         5'h01: f = '{11'd1009, 10'd673, 9'd336, GEAR_48};
         5'h02: f = '{11'd1080, 10'd720, 9'd360, GEAR_48};
         5'h03: f = '{11'd1012, 10'd675, 9'd337, GEAR_48};
         5'h04: f = '{11'd1140, 10'd760, 9'd380, GEAR_48};
         5'h05: f = '{11'd1170, 10'd780, 9'd390, GEAR_48};
         5'h06: f = '{11'd1200, 10'd800, 9'd400, GEAR_48};
         5'h07: f = '{11'd1230, 10'd820, 9'd410, GEAR_48};
         5'h08: f = '{11'd1257, 10'd629, 9'd314, GEAR_64};
         5'h09: f = '{11'd1303, 10'd651, 9'd326, GEAR_64};
         5'h0A: f = '{11'd1339, 10'd670, 9'd335, GEAR_64};
         5'h0B: f = '{11'd1342, 10'd671, 9'd336, GEAR_64};
         5'h0C: f = '{11'd1345, 10'd673, 9'd336, GEAR_64};
         5'h0D: f = '{11'd1480, 10'd740, 9'd370, GEAR_64};
         5'h0E: f = '{11'd1520, 10'd760, 9'd380, GEAR_64};
         5'h0F: f = '{11'd1560, 10'd780, 9'd390, GEAR_64};
         5'h10: f = '{11'd1600, 10'd800, 9'd400, GEAR_64};
         5'h11: f = '{11'd1640, 10'd820, 9'd410, GEAR_64};
         5'h12: f = '{11'd1674, 10'd669, 9'd335, GEAR_96};
         5'h13: f = '{11'd1700, 10'd680, 9'd340, GEAR_96};
         5'h14: f = '{11'd1750, 10'd700, 9'd350, GEAR_96};
         5'h15: f = '{11'd1800, 10'd720, 9'd360, GEAR_96};
         5'h16: f = '{11'd1850, 10'd740, 9'd370, GEAR_96};
         5'h17: f = '{11'd1900, 10'd760, 9'd380, GEAR_96};
         5'h18: f = '{11'd1668, 10'd667, 9'd334, GEAR_96};
         5'h19: f = '{11'd1002, 10'd668, 9'd334, GEAR_48};
         5'h1A: f = '{11'd1336, 10'd668, 9'd334, GEAR_64};
         5'h1B: f = '{11'd2004, 10'd668, 9'd334, GEAR_96};
         5'h1C: f = '{11'd1666, 10'd666, 9'd333, GEAR_96};
         5'h1D: f = '{11'd1000, 10'd666, 9'd333, GEAR_48};
         5'h1E: f = '{11'd2000, 10'd666, 9'd333, GEAR_96};
         5'h1F: f = '{11'd1333, 10'd666, 9'd333, GEAR_64};
      endcase
      return f;
   endfunction : freq_decode
endpackage : smbus_cfg_pkg

// *** dv/smbus_host_model.sv ***
// SMBus host controller model driving the clock and data pins of the configuration port
module smbus_host_model (
   input wire logic clk_i,
   input wire logic sda_wire_i,
   output logic scl_o,
   output logic sda_drv_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Cleared when the port fails to acknowledge a byte it should accept
   logic ack_ok;
   // Bus idles released; the pull-up holds data high
   initial begin
      scl_o = 1'b1;
      sda_drv_o = 1'b1;
      ack_ok = 1'b1;
   end
   // One third of a bit; long enough to absorb the port's one-cycle ack latency
   task automatic step(input logic c, input logic d);
      scl_o <= c;
      sda_drv_o <= d;
      repeat (4) @(posedge clk_i);
   endtask : step
   // Start and repeated start: data falls while the clock is high
   task automatic start();
      @(posedge clk_i);
      if (!scl_o) begin
         step(1'b0, 1'b1);
      end
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : start
   // Stop: data rises while the clock is high
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : stop
   // Data held across the fall too, so no edge looks like a start or stop
   task automatic bit_io(input logic v, output logic r);
      step(1'b0, v);
      step(1'b1, v);
      r = sda_wire_i;
      step(1'b0, v);
   endtask : bit_io
   // A byte MSB first, then the ninth bit; send FF to read, ack_in low to acknowledge
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic acked);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(ack_in, r);
      acked = !r;
   endtask : xfer
   // A byte the port must acknowledge
   task automatic put(input logic [7:0] b);
      logic [7:0] rx;
      logic ak;
      xfer(b, 1'b1, rx, ak);
      if (ak !== 1'b1) begin
         ack_ok = 1'b0;
      end
   endtask : put
   // Start, own address with write bit, command byte
   task automatic head(input logic [7:0] cmd);
      start();
      put(8'hD2);
      put(cmd);
   endtask : head
   task automatic byte_write(input logic [6:0] idx, input logic [7:0] d);
      head({1'b1, idx});
      put(d);
      stop();
   endtask : byte_write
   // Last byte left unacknowledged so the port lets go of the line
   task automatic byte_read(input logic [6:0] idx, output logic [7:0] d);
      logic ak;
      head({1'b1, idx});
      start();
      put(8'hD3);
      xfer(8'hFF, 1'b1, d, ak);
      stop();
   endtask : byte_read
   // Optional tail of loose bits models a host giving up inside a byte
   task automatic block_write(input int n, input logic [63:0] d, input int tail);
      logic r;
      head(8'h00);
      put(n[7:0]);
      for (int i = 0; i < n; i++) begin
         put(d[63 - 8 * i -: 8]);
      end
      repeat (tail) begin
         bit_io(1'b1, r);
      end
      stop();
   endtask : block_write
   task automatic block_read(input int n, output logic [7:0] cnt, output logic [63:0] d);
      logic [7:0] b;
      logic ak;
      d = '0;
      head(8'h00);
      start();
      put(8'hD3);
      xfer(8'hFF, 1'b0, cnt, ak);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, i == n - 1, b, ak);
         d[63 - 8 * i -: 8] = b;
      end
      stop();
   endtask : block_read
endmodule : smbus_host_model

// *** dv/test_clock_synth_smbus_config_port.sv ***
// Self-checking bench for the clock synthesizer SMBus configuration port
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_clock_synth_smbus_config_port;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [4:0] code;
      logic [10:0] cpu;
      logic [9:0] hub;
      logic [8:0] pci;
      logic [1:0] gear;
   } row_s;
   // Codes at the edges of each gear range, with their frequencies
   row_s rows [8] = '{
      '{5'h00, 11'h3EF, 10'h29F, 9'h150, 2'h0}, '{5'h07, 11'h4CE, 10'h334, 9'h19A, 2'h0},
      '{5'h08, 11'h4E9, 10'h275, 9'h13A, 2'h1}, '{5'h11, 11'h668, 10'h334, 9'h19A, 2'h1},
      '{5'h12, 11'h68A, 10'h29D, 9'h14F, 2'h2}, '{5'h18, 11'h684, 10'h29B, 9'h14E, 2'h2},
      '{5'h19, 11'h3EA, 10'h29C, 9'h14E, 2'h0}, '{5'h1F, 11'h535, 10'h29A, 9'h14D, 2'h1}};
   // Neighbouring address, then a command and data that would clear byte 1
   logic [7:0] foreign [3] = '{8'hD4, 8'h81, 8'h00};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pg_n = 1'b1;
   logic [4:0] strap = 5'h12;
   logic [1:0] swing = 2'h2;
   logic sw_src = 1'b0;
   logic scl;
   logic sda_drv;
   logic oe;
   logic sda_wire;
   int error_cnt = 0;
   int checks = 0;
   int cycles = 0;
   // 40 MHz system clock
   always #12.5 clk = ~clk;
   // Open-drain data line with pull-up
   assign sda_wire = sda_drv & ~oe;
   clock_synth_smbus_config_port i_dut (
      .sys_clk_i(clk),
      .sys_rst_i(rst),
      .scl_i(scl),
      .serial_data_pin_i(sda_wire),
      .serial_data_pin_o(),
      .serial_data_pin_oe_o(oe),
      .supply_good_n_i(pg_n),
      .freq_strap_code_i(strap),
      .swing_select_i(swing),
      .sw_freq_src_i(sw_src),
      .swing_select_o(),
      .freq_code_o(),
      .cpu_freq_o(),
      .hub_clock_66_freq_o(),
      .pci_freq_o(),
      .gear_o(),
      .out_enable_o()
   );
   smbus_host_model i_host (
      .clk_i(clk),
      .sda_wire_i(sda_wire),
      .scl_o(scl),
      .sda_drv_o(sda_drv)
   );
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   // Reset held 9 cycles; defaults must show right after release
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      `CHK("enables in reset", 16'h0000, i_dut.out_enable_o)
      `CHK("oe in reset", 1'b0, oe)
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("default enables", 16'hFF7F, i_dut.out_enable_o)
      `CHK("default cpu", 11'h3EF, i_dut.cpu_freq_o)
      `CHK("data out", 1'b0, i_dut.serial_data_pin_o)
      $display("test reset done");
   endtask : do_reset
   // Cuts a hang short; the run needs about 10400 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      logic [7:0] b;
      logic [7:0] cnt;
      logic [63:0] blk;
      logic ak;
      do_reset();
      // Straps latch on the first low of supply good and are then frozen
      @(posedge clk);
      pg_n <= 1'b0;
      repeat (2) @(posedge clk);
      pg_n <= 1'b1;
      strap <= 5'h05;
      swing <= 2'h1;
      // A second low of supply good must not take the new straps
      repeat (2) @(posedge clk);
      pg_n <= 1'b0;
      repeat (2) @(posedge clk);
      pg_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      `CHK("strap code", 5'h12, i_dut.freq_code_o)
      `CHK("swing", 2'h2, i_dut.swing_select_o)
      `CHK("strap cpu", 11'h68A, i_dut.cpu_freq_o)
      $display("test strap done");
      @(posedge clk);
      sw_src <= 1'b1;
      // Software code written by byte access, decoded and read back
      foreach (rows[k]) begin
         i_host.byte_write(7'h00, {3'h0, rows[k].code});
         repeat (4) @(posedge clk);
         #1;
         `CHK("code", rows[k].code, i_dut.freq_code_o)
         `CHK("cpu", rows[k].cpu, i_dut.cpu_freq_o)
         `CHK("hub", rows[k].hub, i_dut.hub_clock_66_freq_o)
         `CHK("pci", rows[k].pci, i_dut.pci_freq_o)
         `CHK("gear", rows[k].gear, i_dut.gear_o)
         i_host.byte_read(7'h00, b);
         `CHK("byte0", {3'h0, rows[k].code}, b)
      end
      $display("test decode done");
      // Three whole bytes, then four loose bits before the stop
      i_host.block_write(3, 64'h13A5_3C00_0000_0000, 4);
      repeat (4) @(posedge clk);
      #1;
      `CHK("block enables", 16'hA53C, i_dut.out_enable_o)
      `CHK("block code", 5'h13, i_dut.freq_code_o)
      i_host.byte_read(7'h03, b);
      `CHK("torn byte", 8'h00, b)
      $display("test block write done");
      i_host.block_read(8, cnt, blk);
      `CHK("count", 8'h08, cnt)
      `CHK("block data", 64'h13A5_3C00_0000_0000, blk)
      $display("test block read done");
      // Index past the table is acknowledged, dropped and reads zero
      i_host.byte_write(7'h09, 8'hAA);
      i_host.byte_read(7'h09, b);
      `CHK("reserved", 8'h00, b)
      `CHK("acks", 1'b1, i_host.ack_ok)
      $display("test reserved done");
      i_host.start();
      foreach (foreign[j]) begin
         i_host.xfer(foreign[j], 1'b1, b, ak);
         `CHK("foreign ack", 1'b0, ak)
      end
      i_host.stop();
      #1;
      `CHK("enables kept", 16'hA53C, i_dut.out_enable_o)
      $display("test foreign address done");
      do_reset();
      tally_and_finish();
   end
endmodule : test_clock_synth_smbus_config_port
